/* File: hdl/agp_aux_gpio.sv */
// auxiliary pin pair: direction, drive, bias, read-back and process data links
`timescale 1ns/100ps
module agp_aux_gpio
(
	input  wire logic                                        ref_clk_in,
	input  wire logic                                        arst_n_in,
	input  wire logic                                        reg_wr_in,
	input  wire logic                                        reg_rd_in,
	input  wire logic [7:0]                                  reg_addr_in,
	input  wire logic [7:0]                                  reg_wdata_in,
	output logic      [7:0]                                  reg_rdata_out,
	input  wire logic [agp_pkg::AGP_PIN_COUNT-1:0]           aux_pin_in,
	output agp_pkg::agp_pin_drive_t [agp_pkg::AGP_PIN_COUNT-1:0] aux_pin_drive_out,
	input  wire agp_pkg::agp_byte_t                          pdin_in,
	input  wire logic                                        process_data_invalid_flag_in,
	output agp_pkg::agp_byte_t                               pdin_out,
	input  wire agp_pkg::agp_byte_t                          pdout_in
);

	logic [7:0]                        ctrl [agp_pkg::AGP_PIN_COUNT];
	logic [agp_pkg::AGP_PIN_COUNT-1:0] level;
	logic [agp_pkg::AGP_PIN_COUNT-1:0] eff_out;
	logic [agp_pkg::AGP_PIN_COUNT-1:0] eff_val;
	logic [7:0]                        view [agp_pkg::AGP_PIN_COUNT];
	logic                              mirror_bit;
	logic                              pin1_link;
	logic                              pin2_link;

	assign pin1_link = ctrl[0][agp_pkg::AGP_BIT_LINK] & ~eff_out[0];
	assign pin2_link = ctrl[1][agp_pkg::AGP_BIT_LINK];

	// ----------------------------------------------------------------
	// per pin: synchroniser, control register, drive stage
	// ----------------------------------------------------------------
	for (genvar i = 0; i < agp_pkg::AGP_PIN_COUNT; i++)
	begin : g_pin
		logic [agp_pkg::AGP_SYNC_STAGES-1:0] sync;
		localparam logic [7:0] ADDR = (i == 0) ? agp_pkg::AGP_ADDR_PIN1 : agp_pkg::AGP_ADDR_PIN2;
		localparam bit         IS_PIN2 = (i == 1);

		// pin level is asynchronous; only stage 2, sync[1], is ever read
		always_ff @(posedge ref_clk_in or negedge arst_n_in)
		begin
			if (!arst_n_in)
				sync <= '0;
			else
				sync <= {sync[0], aux_pin_in[i]};
		end
		assign level[i] = sync[1];

		always_ff @(posedge ref_clk_in or negedge arst_n_in)
		begin
			if (!arst_n_in)
				ctrl[i] <= agp_pkg::AGP_CTRL_RESET;
			else if (reg_wr_in && reg_addr_in == ADDR)
				ctrl[i] <= reg_wdata_in & agp_pkg::AGP_CTRL_WR_MASK;
		end

		// pin 2 mirror flag forces output and overrides the value bit
		assign eff_out[i] = ctrl[i][agp_pkg::AGP_BIT_DIRECTION]
			| (IS_PIN2 & ctrl[i][agp_pkg::AGP_BIT_LINK]);
		assign eff_val[i] = (IS_PIN2 && ctrl[i][agp_pkg::AGP_BIT_LINK]) ?
			mirror_bit : ctrl[i][agp_pkg::AGP_BIT_OUTPUT_VALUE];

		assign view[i] = {level[i], 1'b0,
			ctrl[i][agp_pkg::AGP_BIT_LINK:agp_pkg::AGP_BIT_OPEN_DRAIN],
			eff_out[i] ? ctrl[i][agp_pkg::AGP_BIT_OUTPUT_VALUE] : level[i],
			ctrl[i][agp_pkg::AGP_BIT_DIRECTION:agp_pkg::AGP_BIT_RESISTOR_DIS]};

		always_ff @(posedge ref_clk_in or negedge arst_n_in)
		begin
			if (!arst_n_in)
			begin
				aux_pin_drive_out[i] <= '{level: 1'b0, oe_n: 1'b1, pull_up: 1'b0,
					pull_down: 1'b0};
			end
			else
			begin
				aux_pin_drive_out[i].level <= eff_val[i];
				// open drain only ever pulls low, high means released
				aux_pin_drive_out[i].oe_n <= ~(eff_out[i] &
					(~ctrl[i][agp_pkg::AGP_BIT_OPEN_DRAIN] | ~eff_val[i]));
				aux_pin_drive_out[i].pull_up <= ~eff_out[i]
					& ~ctrl[i][agp_pkg::AGP_BIT_RESISTOR_DIS]
					& ctrl[i][agp_pkg::AGP_BIT_PULL_SELECT];
				aux_pin_drive_out[i].pull_down <= ~eff_out[i]
					& ~ctrl[i][agp_pkg::AGP_BIT_RESISTOR_DIS]
					& ~ctrl[i][agp_pkg::AGP_BIT_PULL_SELECT];
			end
		end
	end

	// ----------------------------------------------------------------
	// register read-back, one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			reg_rdata_out <= agp_pkg::AGP_RDATA_UNMAPPED;
		else if (reg_rd_in)
		begin
			if (reg_addr_in == agp_pkg::AGP_ADDR_PIN1)
				reg_rdata_out <= view[0];
			else if (reg_addr_in == agp_pkg::AGP_ADDR_PIN2)
				reg_rdata_out <= view[1];
			else
				reg_rdata_out <= agp_pkg::AGP_RDATA_UNMAPPED;
		end
	end

	// ----------------------------------------------------------------
	// process data links
	// ----------------------------------------------------------------
	// held between bytes so the pin does not glitch mid-frame
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			mirror_bit <= 1'b0;
		else if (pdout_in.valid)
			mirror_bit <= pdout_in.data[0];
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pdin_out <= '{valid: 1'b0, data: agp_pkg::AGP_PDIN_INVALID};
		else
		begin
			pdin_out.valid <= pdin_in.valid;
			if (pdin_in.valid)
			begin
				pdin_out.data <= process_data_invalid_flag_in ?
					agp_pkg::AGP_PDIN_INVALID : pdin_in.data;
				if (pin1_link)
					pdin_out.data[0] <= ~level[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	// one received byte, then a quiet cycle for the pin to follow
	sequence s_mirror_byte;
		pdout_in.valid && pin2_link ##1 pin2_link && !pdout_in.valid;
	endsequence

	// two quiet cycles: the mirrored level has no reason to move
	sequence s_mirror_idle;
		pin2_link && !pdout_in.valid ##1 pin2_link && !pdout_in.valid;
	endsequence

	// process data path
	pdin_zero_a: assert property (
		pdin_in.valid && process_data_invalid_flag_in && !pin1_link
		|=> pdin_out.data == agp_pkg::AGP_PDIN_INVALID)
		else $error("invalid pdin not zero");
	pdin_lsb_a: assert property (
		pdin_in.valid && pin1_link
		|=> pdin_out.valid && pdin_out.data[0] == !$past(level[0]))
		else $error("pdin lsb wrong");
	pdin_upper_a: assert property (
		pdin_in.valid && !process_data_invalid_flag_in
		|=> pdin_out.data[7:1] == $past(pdin_in.data[7:1]))
		else $error("pdin data altered");

	// pin 2 mirror
	mirror_pin2_a: assert property (
		s_mirror_byte
		|=> aux_pin_drive_out[1].level == $past(pdout_in.data[0], 2)
		&& (!aux_pin_drive_out[1].oe_n || $past(ctrl[1][agp_pkg::AGP_BIT_OPEN_DRAIN])))
		else $error("pin 2 not mirroring pdout");
	mirror_hold_a: assert property (
		s_mirror_idle
		|=> $stable(aux_pin_drive_out[1].level))
		else $error("pin 2 moved between bytes");

	// drive stages
	od_release_a: assert property (
		eff_out[0] && ctrl[0][agp_pkg::AGP_BIT_OPEN_DRAIN] && eff_val[0]
		|=> aux_pin_drive_out[0].oe_n)
		else $error("open drain drove high");
	od_low_a: assert property (
		eff_out[0] && ctrl[0][agp_pkg::AGP_BIT_OPEN_DRAIN] && !eff_val[0]
		|=> !aux_pin_drive_out[0].oe_n && !aux_pin_drive_out[0].level)
		else $error("open drain did not pull low");
	push_pull_a: assert property (
		eff_out[0] && !ctrl[0][agp_pkg::AGP_BIT_OPEN_DRAIN]
		|=> !aux_pin_drive_out[0].oe_n
		&& aux_pin_drive_out[0].level == $past(ctrl[0][agp_pkg::AGP_BIT_OUTPUT_VALUE]))
		else $error("push-pull level wrong");
	input_hiz_a: assert property (
		!eff_out[1]
		|=> aux_pin_drive_out[1].oe_n
		&& !(aux_pin_drive_out[1].pull_up && aux_pin_drive_out[1].pull_down))
		else $error("input pin driven");
	pull_select_a: assert property (
		!eff_out[0] && !ctrl[0][agp_pkg::AGP_BIT_RESISTOR_DIS]
		|=> aux_pin_drive_out[0].pull_up == $past(ctrl[0][agp_pkg::AGP_BIT_PULL_SELECT])
		&& aux_pin_drive_out[0].pull_down != aux_pin_drive_out[0].pull_up)
		else $error("pull selection wrong");
	pin2_pull_a: assert property (
		!eff_out[1] && !ctrl[1][agp_pkg::AGP_BIT_RESISTOR_DIS]
		|=> aux_pin_drive_out[1].pull_up == $past(ctrl[1][agp_pkg::AGP_BIT_PULL_SELECT])
		&& aux_pin_drive_out[1].pull_down != aux_pin_drive_out[1].pull_up)
		else $error("pin 2 pull selection wrong");
	pull_off_a: assert property (
		eff_out[0] || ctrl[0][agp_pkg::AGP_BIT_RESISTOR_DIS]
		|=> !aux_pin_drive_out[0].pull_up && !aux_pin_drive_out[0].pull_down)
		else $error("pull left on");

	// register read-back and write masking
	din_read_a: assert property (
		reg_rd_in && reg_addr_in == agp_pkg::AGP_ADDR_PIN1 && !eff_out[0]
		|=> reg_rdata_out[agp_pkg::AGP_BIT_INPUT_LEVEL] == $past(level[0])
		&& reg_rdata_out[agp_pkg::AGP_BIT_OUTPUT_VALUE] == $past(level[0])
		&& !reg_rdata_out[agp_pkg::AGP_BIT_UNUSED])
		else $error("pin 1 read-back wrong");
	din2_read_a: assert property (
		reg_rd_in && reg_addr_in == agp_pkg::AGP_ADDR_PIN2
		|=> reg_rdata_out[agp_pkg::AGP_BIT_INPUT_LEVEL] == $past(level[1])
		&& !reg_rdata_out[agp_pkg::AGP_BIT_UNUSED])
		else $error("pin 2 read-back wrong");
	ctrl_write_a: assert property (
		reg_wr_in && reg_addr_in == agp_pkg::AGP_ADDR_PIN2
		|=> ctrl[1] == ($past(reg_wdata_in) & agp_pkg::AGP_CTRL_WR_MASK))
		else $error("pin 2 write not masked");

endmodule

/* File: hdl/agp_pkg.sv */
// constants and carrier types for the auxiliary pin pair control
package agp_pkg;

	// ----------------------------------------------------------------
	// register addresses on the register port
	// ----------------------------------------------------------------
	localparam logic [7:0] AGP_ADDR_PIN1 = 8'h54;
	localparam logic [7:0] AGP_ADDR_PIN2 = 8'h55;

	// ----------------------------------------------------------------
	// control register field positions
	// ----------------------------------------------------------------
	localparam int AGP_BIT_INPUT_LEVEL   = 7;
	localparam int AGP_BIT_UNUSED        = 6;
	localparam int AGP_BIT_LINK          = 5;
	localparam int AGP_BIT_OPEN_DRAIN    = 4;
	localparam int AGP_BIT_OUTPUT_VALUE  = 3;
	localparam int AGP_BIT_DIRECTION     = 2;
	localparam int AGP_BIT_PULL_SELECT   = 1;
	localparam int AGP_BIT_RESISTOR_DIS  = 0;

	// ----------------------------------------------------------------
	// reset and write masks
	// ----------------------------------------------------------------
	localparam logic [7:0] AGP_CTRL_RESET    = 8'h00;
	localparam logic [7:0] AGP_CTRL_WR_MASK  = 8'h3F;
	localparam logic [7:0] AGP_RDATA_UNMAPPED = 8'h00;
	localparam logic [7:0] AGP_PDIN_INVALID   = 8'h00;
	localparam int         AGP_SYNC_STAGES    = 2;
	localparam int         AGP_PIN_COUNT      = 2;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic level;
		logic oe_n;
		logic pull_up;
		logic pull_down;
	} agp_pin_drive_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} agp_byte_t;

endpackage

/* File: tb/agp_pin_model.sv */
// wire model of the circuitry on the two auxiliary pins
`timescale 1ns/100ps
module agp_pin_model
(
	input  wire agp_pkg::agp_pin_drive_t [1:0] drive_in,
	input  wire logic [1:0]                    ext_en_in,
	input  wire logic [1:0]                    ext_in,
	output logic      [1:0]                    pin_out
);
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (!drive_in[i].oe_n)
				pin_out[i] = drive_in[i].level;
			else if (ext_en_in[i])
				pin_out[i] = ext_in[i];
			else if (drive_in[i].pull_up || drive_in[i].pull_down)
				pin_out[i] = drive_in[i].pull_up;
			else
				// floating: inverse of last drive, so a stale value never matches
				pin_out[i] = ~drive_in[i].level;
		end
	end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the auxiliary pin pair
`timescale 1ns/100ps
module testbench;
	logic                          ref_clk_in = 1'b0;
	logic                          arst_n_in = 1'b0;
	logic                          wr = 1'b0;
	logic                          rd = 1'b0;
	logic [7:0]                    addr = 8'h00;
	logic [7:0]                    wdata = 8'h00;
	logic [7:0]                    rdata;
	logic [1:0]                    pins;
	logic [1:0]                    ext_en = 2'h0;
	logic [1:0]                    ext = 2'h0;
	logic                          pd_bad = 1'b0;
	agp_pkg::agp_pin_drive_t [1:0] drv;
	agp_pkg::agp_byte_t            pdin = '0;
	agp_pkg::agp_byte_t            pdout = '0;
	agp_pkg::agp_byte_t            pdin_res;
	int                            failures = 0;
	int                            check_count = 0;
	always #12.5 ref_clk_in = ~ref_clk_in;
	agp_aux_gpio u_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.aux_pin_in(pins), .aux_pin_drive_out(drv), .pdin_in(pdin),
		.process_data_invalid_flag_in(pd_bad), .pdin_out(pdin_res), .pdout_in(pdout));
	agp_pin_model u_pins (.drive_in(drv), .ext_en_in(ext_en), .ext_in(ext), .pin_out(pins));
	task automatic cmp(input string what, input logic [8:0] exp, input logic [8:0] got);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_in);
		wr <= 1'b0;
		repeat (5) @(posedge ref_clk_in);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_in);
		rd <= 1'b0;
		#1 cmp("read data", {1'b0, exp}, {1'b0, rdata});
		@(posedge ref_clk_in);
	endtask
	task automatic chk_drv(input int p, input logic [3:0] mask, input logic [3:0] exp);
		cmp("pin drive", {5'h00, exp & mask}, {5'h00, drv[p] & mask});
	endtask
	task automatic send_byte(input bit to_pdout, input logic [7:0] d, input logic [7:0] exp);
		if (to_pdout)
			pdout <= '{valid: 1'b1, data: d};
		else
			pdin <= '{valid: 1'b1, data: d};
		@(posedge ref_clk_in);
		pdout.valid <= 1'b0;
		pdin.valid <= 1'b0;
		#1 if (!to_pdout) cmp("pdin byte", {1'b1, exp}, pdin_res);
		@(posedge ref_clk_in);
		#1 if (to_pdout) chk_drv(1, 4'hF, {exp[0], 3'h0});
		@(posedge ref_clk_in);
	endtask
	task automatic t_reset;
		rd_reg(8'h54, 8'h00);
		rd_reg(8'h55, 8'h00);
		rd_reg(8'h60, 8'h00);
		chk_drv(0, 4'hF, 4'h5);
		$display("test reset done");
	endtask
	task automatic t_output;
		ext_en[0] <= 1'b1;
		ext[0] <= 1'b1;
		wr_reg(8'h54, 8'hFF);
		chk_drv(0, 4'hF, 4'hC);
		rd_reg(8'h54, 8'hBF);
		ext_en[0] <= 1'b0;
		wr_reg(8'h54, 8'h04);
		chk_drv(0, 4'hF, 4'h0);
		wr_reg(8'h54, 8'h14);
		chk_drv(0, 4'hF, 4'h0);
		$display("test output done");
	endtask
	task automatic t_bias;
		for (int p = 0; p < 2; p++)
		begin
			ext_en[p] <= 1'b0;
			wr_reg(8'h54 + 8'(p), 8'h02);
			chk_drv(p, 4'h7, 4'h6);
			ext_en[p] <= 1'b1;
			ext[p] <= 1'b1;
			wr_reg(8'h54 + 8'(p), 8'h01);
			chk_drv(p, 4'h7, 4'h4);
			rd_reg(8'h54 + 8'(p), 8'h89);
		end
		$display("test bias done");
	endtask
	task automatic t_link;
		ext[0] <= 1'b0;
		wr_reg(8'h54, 8'h21);
		send_byte(1'b0, 8'hA4, 8'hA5);
		ext[0] <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		send_byte(1'b0, 8'hA5, 8'hA4);
		pd_bad <= 1'b1;
		ext[0] <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		send_byte(1'b0, 8'hFE, 8'h01);
		wr_reg(8'h54, 8'h01);
		send_byte(1'b0, 8'hFE, 8'h00);
		$display("test link done");
	endtask
	task automatic t_mirror;
		ext_en[1] <= 1'b0;
		wr_reg(8'h55, 8'h28);
		chk_drv(1, 4'hF, 4'h0);
		send_byte(1'b1, 8'h01, 8'h01);
		send_byte(1'b1, 8'hFE, 8'h00);
		$display("test mirror done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		t_reset();
		t_output();
		t_bias();
		t_link();
		t_mirror();
		end_of_test();
	end
	initial
	begin
		// generous span: the tests need about 110 cycles
		repeat (5000) @(posedge ref_clk_in);
		failures++;
		end_of_test();
	end
endmodule
